// ---- design/tss_consts.svh ----
// What this block does
// - Accept 128-element paths with 11-bit score keys.
// - Carry 7-bit position tag through sorting.
// - Join 5-bit cyclic id 0..31 at entry.
// - Stage one: 16 lists of 8, 7 cycles.
// - Stage two: 8 lists of 16, 3 cycles.
// - Stage three: 4 lists of 32, 3 cycles.
// - Stage three adds 2-bit list index.
// - Stages are bitonic compare-exchange networks.
// - Stage four inserts best into bubble list.
// - Insert at bottom only if larger, else discard.
// - Each neighbour pair compared and swapped every other cycle.
// - Upstream holds until insertion of path ends.
// - Run list-depth extra cycles before final.
// - Result list depth parameter, default 200.
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH
`define TSS_PATH_LEN 128
`define TSS_SCORE_W 11
`define TSS_TAG_W 7
`define TSS_CID_W 5
`define TSS_LIST_W 2
`define TSS_LISTS 4
`define TSS_LIST_LEN 32
`define TSS_PATH_W 14
`define TSS_S1_LAT 7
`define TSS_S2_LAT 3
`define TSS_S3_LAT 3
`define TSS_RES_DEPTH 200
`endif

// ---- design/tss_pkg.sv ----
`include "tss_consts.svh"
package tss_pkg;
  typedef struct packed {
    logic [`TSS_SCORE_W-1:0] score;
    logic [`TSS_TAG_W-1:0] tag;
  } tss_elem_t;
  typedef tss_elem_t [`TSS_PATH_LEN-1:0] tss_path_t;
  typedef struct packed {
    logic [`TSS_SCORE_W-1:0] score;
    logic [`TSS_TAG_W-1:0] tag;
    logic [`TSS_PATH_W-1:0] path;
  } tss_entry_t;
  typedef enum logic [4:0] {
    TSS_ST_IDLE = 5'h01,
    TSS_ST_SORT = 5'h02,
    TSS_ST_INSERT = 5'h04,
    TSS_ST_FLUSH = 5'h08,
    TSS_ST_DONE = 5'h10
  } tss_state_t;
endpackage

// ---- design/tss_bitonic_stage.sv ----
`timescale 1ns/1ps
`include "tss_consts.svh"
module tss_bitonic_stage import tss_pkg::*; #(
  parameter int KMIN = 2,
  parameter int KMAX = 8,
  parameter int LAT = 7,
  parameter bit DESC_LAST = 1'b0
) (
  input wire logic sys_clk, // Processing clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic inValid, // A path enters this stage.
  input tss_path_t inData, // Elements entering.
  output logic outValid, // The path leaves, LAT cycles later.
  output tss_path_t outData // Ordered sublists.
);
  tss_path_t net;
  tss_path_t pipe [LAT];
  tss_path_t next_pipe [LAT];
  logic [LAT-1:0] vld;
  logic [LAT-1:0] next_vld;

  ////////////////////////////////////////////////////////////////////////////
  // Sublists of KMIN/2 arrive alternately ascending and descending, so each
  // pair already forms a bitonic sequence and only the merge levels run here.
  always_comb begin
    tss_elem_t a;
    tss_elem_t b;
    logic desc;
    a = '0;
    b = '0;
    desc = 1'b0;
    net = inData;
    for (int k = KMIN; k <= KMAX; k = k * 2) begin
      for (int j = k / 2; j > 0; j = j / 2) begin
        for (int i = 0; i < `TSS_PATH_LEN; i++) begin
          if ((i & j) == 0) begin
            a = net[i];
            b = net[i | j];
            desc = (DESC_LAST && k == KMAX) ? 1'b1 : ((i & k) != 0);
            if (desc ? (a.score < b.score) : (a.score > b.score)) begin
              net[i] = b;
              net[i | j] = a;
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The network settles in one cycle; the pipe holds it to the fixed latency.
  always_comb begin
    next_pipe[0] = net;
    for (int s = 1; s < LAT; s++) begin
      next_pipe[s] = pipe[s-1];
    end
    next_vld = {vld[LAT-2:0], inValid};
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vld <= '0;
      for (int s = 0; s < LAT; s++) begin
        pipe[s] <= '0;
      end
    end else begin
      vld <= next_vld;
      for (int s = 0; s < LAT; s++) begin
        pipe[s] <= next_pipe[s];
      end
    end
  end

  assign outValid = vld[LAT-1];
  assign outData = pipe[LAT-1];
endmodule

// ---- design/tss_top_sorter.sv ----
`timescale 1ns/1ps
`include "tss_consts.svh"
module tss_top_sorter import tss_pkg::*; #(
  parameter int RES_DEPTH = `TSS_RES_DEPTH
) (
  input wire logic sys_clk, // Processing clock, 100 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic pathValid, // Upstream offers a path.
  input wire logic [`TSS_PATH_LEN-1:0][`TSS_SCORE_W-1:0] pathScores, // Scores of the path.
  input wire logic lastPath, // Offered path is the last of the database.
  input wire logic queryStart, // Pulse in idle or done: clear the list for a new query.
  output logic pathReady, // Sorter can take a path.
  output tss_entry_t resultList [RES_DEPTH], // Result list, top at the highest index.
  output logic resultFinal // Result list is final.
);
  localparam int CID_W = `TSS_CID_W;
  localparam int LIST_W = `TSS_LIST_W;
  localparam int PTR_W = $clog2(`TSS_LIST_LEN + 1);
  localparam int CNT_W = $clog2(RES_DEPTH + 1);
  localparam int LISTS = `TSS_LISTS;
  localparam int LLEN = `TSS_LIST_LEN;

  tss_state_t state;
  tss_state_t next_state;
  tss_path_t s1In;
  tss_path_t s1Out;
  tss_path_t s2Out;
  tss_path_t s3Out;
  logic s1Val;
  logic s2Val;
  logic s3Val;
  logic accept;
  logic clearList;
  tss_elem_t cand [LISTS][LLEN];
  tss_elem_t next_cand [LISTS][LLEN];
  logic [PTR_W-1:0] ptr [LISTS];
  logic [PTR_W-1:0] next_ptr [LISTS];
  tss_entry_t next_resultList [RES_DEPTH];
  logic lastFlag;
  logic next_lastFlag;
  logic [`TSS_PATH_W-1:0] pathNum;
  logic [`TSS_PATH_W-1:0] next_pathNum;
  logic [CNT_W-1:0] flushCnt;
  logic [CNT_W-1:0] next_flushCnt;
  logic phase;
  logic next_phase;
  tss_elem_t best;
  logic [LIST_W-1:0] bestIdx;
  logic anyHead;
  logic doInsert;
  logic [`TSS_SCORE_W-1:0] bestScore;

  ////////////////////////////////////////////////////////////////////////////
  // Entry: each score is tagged with its position inside a 32-element group.
  // A query start wins over an offered path, so ready drops to keep the offer held, not lost.
  assign pathReady = (state == TSS_ST_IDLE) && !queryStart;
  assign accept = pathValid && pathReady;
  assign clearList = queryStart && (state == TSS_ST_IDLE || state == TSS_ST_DONE);
  assign resultFinal = (state == TSS_ST_DONE);

  always_comb begin
    for (int i = 0; i < `TSS_PATH_LEN; i++) begin
      s1In[i].score = pathScores[i];
      s1In[i].tag = {{LIST_W{1'b0}}, CID_W'(i)};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  tss_bitonic_stage #(.KMIN(2), .KMAX(8), .LAT(`TSS_S1_LAT), .DESC_LAST(1'b0)) stageOne (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inValid(accept),
    .inData(s1In),
    .outValid(s1Val),
    .outData(s1Out)
  );

  tss_bitonic_stage #(.KMIN(16), .KMAX(16), .LAT(`TSS_S2_LAT), .DESC_LAST(1'b0)) stageTwo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inValid(s1Val),
    .inData(s1Out),
    .outValid(s2Val),
    .outData(s2Out)
  );

  // The last stage forces every 32-list descending so each head is its best.
  tss_bitonic_stage #(.KMIN(32), .KMAX(32), .LAT(`TSS_S3_LAT), .DESC_LAST(1'b1)) stageThree (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inValid(s2Val),
    .inData(s2Out),
    .outValid(s3Val),
    .outData(s3Out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pick the largest remaining head of the four lists.
  always_comb begin
    best = '0;
    bestIdx = '0;
    anyHead = 1'b0;
    for (int j = 0; j < LISTS; j++) begin
      if (ptr[j] < PTR_W'(LLEN)) begin
        if (!anyHead || cand[j][ptr[j][PTR_W-2:0]].score > best.score) begin
          best = cand[j][ptr[j][PTR_W-2:0]];
          bestIdx = LIST_W'(j);
        end
        anyHead = 1'b1;
      end
    end
  end

  assign bestScore = best.score;
  // Once the best head loses, all later heads lose too, so insertion ends.
  assign doInsert = (state == TSS_ST_INSERT) && anyHead &&
                    (best.score > resultList[0].score);

  ////////////////////////////////////////////////////////////////////////////
  // Control and candidate capture.
  always_comb begin
    next_state = state;
    next_cand = cand;
    next_ptr = ptr;
    next_lastFlag = lastFlag;
    next_pathNum = pathNum;
    next_flushCnt = flushCnt;
    next_phase = ~phase;
    case (state)
      TSS_ST_IDLE: begin
        if (clearList) begin
          next_pathNum = '0;
        end else if (accept) begin
          next_lastFlag = lastPath;
          next_state = TSS_ST_SORT;
        end
      end
      TSS_ST_SORT: begin
        if (s3Val) begin
          for (int j = 0; j < LISTS; j++) begin
            next_ptr[j] = '0;
            for (int e = 0; e < LLEN; e++) begin
              next_cand[j][e] = s3Out[j * LLEN + e];
              next_cand[j][e].tag[`TSS_TAG_W-1 -: LIST_W] = LIST_W'(j);
            end
          end
          next_state = TSS_ST_INSERT;
        end
      end
      TSS_ST_INSERT: begin
        if (doInsert) begin
          next_ptr[bestIdx] = ptr[bestIdx] + PTR_W'(1);
        end else begin
          next_pathNum = pathNum + `TSS_PATH_W'(1);
          next_flushCnt = '0;
          next_state = lastFlag ? TSS_ST_FLUSH : TSS_ST_IDLE;
        end
      end
      TSS_ST_FLUSH: begin
        next_flushCnt = flushCnt + CNT_W'(1);
        if (flushCnt == CNT_W'(RES_DEPTH - 1)) begin
          next_state = TSS_ST_DONE;
        end
      end
      TSS_ST_DONE: begin
        if (clearList) begin
          next_pathNum = '0;
          next_state = TSS_ST_IDLE;
        end
      end
      default: begin
        next_state = TSS_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result list: insert at the bottom, then one odd-even transposition pass.
  // Alternating pair phases keep every swap independent within a cycle.
  always_comb begin
    tss_entry_t tmp;
    tmp = '0;
    next_resultList = resultList;
    if (clearList) begin
      for (int i = 0; i < RES_DEPTH; i++) begin
        next_resultList[i] = '0;
      end
    end else if (doInsert) begin
      next_resultList[0] = '{score: best.score, tag: best.tag, path: pathNum};
    end
    for (int i = 0; i < RES_DEPTH - 1; i++) begin
      if ((i % 2) == int'(phase)) begin
        if (next_resultList[i].score > next_resultList[i+1].score) begin
          tmp = next_resultList[i];
          next_resultList[i] = next_resultList[i+1];
          next_resultList[i+1] = tmp;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TSS_ST_IDLE;
      lastFlag <= 1'b0;
      pathNum <= '0;
      flushCnt <= '0;
      phase <= 1'b0;
      for (int j = 0; j < LISTS; j++) begin
        ptr[j] <= PTR_W'(LLEN);
        for (int e = 0; e < LLEN; e++) begin
          cand[j][e] <= '0;
        end
      end
      for (int i = 0; i < RES_DEPTH; i++) begin
        resultList[i] <= '0;
      end
    end else begin
      state <= next_state;
      lastFlag <= next_lastFlag;
      pathNum <= next_pathNum;
      flushCnt <= next_flushCnt;
      phase <= next_phase;
      cand <= next_cand;
      ptr <= next_ptr;
      resultList <= next_resultList;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  int flushSeen;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flushSeen <= 0;
    end else if (state == TSS_ST_FLUSH) begin
      flushSeen <= flushSeen + 1;
    end else if (state == TSS_ST_IDLE) begin
      flushSeen <= 0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence seqAccept;
    pathValid && pathReady;
  endsequence
  sequence seqPathDone;
    (state == TSS_ST_INSERT) && !doInsert && !lastFlag;
  endsequence

  AST_S1_LATENCY: assert property (seqAccept |-> ##7 s1Val)
    else $error("stage one latency is not seven cycles");
  AST_S1_ORDER: assert property (s1Val |-> s1Out[0].score <= s1Out[7].score)
    else $error("first stage-one list is not ascending");
  AST_S2_LATENCY: assert property (s1Val |-> ##3 s2Val)
    else $error("stage two latency is not three cycles");
  AST_S3_LATENCY: assert property (s2Val |-> ##3 s3Val)
    else $error("stage three latency is not three cycles");
  AST_S3_ORDER: assert property (s3Val |-> s3Out[32].score >= s3Out[63].score)
    else $error("stage three list is not descending");
  AST_LIST_INDEX: assert property ((state == TSS_ST_SORT && s3Val) |=> cand[2][5].tag[6:5] == 2'h2)
    else $error("list index not attached at stage three");
  AST_HOLD_BUSY: assert property (seqAccept |=> !pathReady [*8])
    else $error("ready rose while a path is in flight");
  AST_READY_AFTER: assert property (seqPathDone |=> pathReady)
    else $error("ready did not return after insertion");
  AST_INSERT_BOTTOM: assert property ((doInsert && phase) |=> resultList[0].score == $past(bestScore))
    else $error("candidate not written to bottom slot");
  AST_DISCARD_END: assert property (((state == TSS_ST_INSERT) && !doInsert) |=> state != TSS_ST_INSERT)
    else $error("insertion continued after a losing candidate");
  AST_BUBBLE_SWAP: assert property ((!phase && !clearList &&
      resultList[2].score > resultList[3].score) |=> resultList[3].score > resultList[2].score)
    else $error("neighbour pair was not swapped");
  AST_FLUSH_LEN: assert property ($rose(resultFinal) |-> flushSeen == RES_DEPTH)
    else $error("final flagged without list-depth extra cycles");
  AST_CLEAR: assert property (clearList |=> resultList[RES_DEPTH-1].score == '0 && pathReady)
    else $error("list not cleared by query start");
endmodule

// ---- test/tss_seq_model.sv ----
`timescale 1ns/1ps
`include "tss_consts.svh"
module tss_seq_model (
  input wire logic sys_clk, // Processing clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic pathReady, // Sorter can take a path.
  output logic pathValid, // A path is offered.
  output logic [`TSS_PATH_LEN-1:0][`TSS_SCORE_W-1:0] pathScores, // Offered scores.
  output logic lastPath // Offered path closes the database.
);
  logic [`TSS_PATH_LEN-1:0][`TSS_SCORE_W-1:0] qScores [$];
  logic qLast [$];

  initial begin
    pathValid = 1'b0;
    pathScores = '0;
    lastPath = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic offer(input logic [`TSS_PATH_LEN-1:0][`TSS_SCORE_W-1:0] s, input logic last);
    qScores.push_back(s);
    qLast.push_back(last);
  endtask

  // The sequencer stays stalled with its offer frozen until the sorter takes it.
  // Once nothing is offered, the lines keep changing so stale data is never trusted.
  always @(posedge sys_clk) begin
    if (rst_n && pathValid && pathReady) begin
      qScores.delete(0);
      qLast.delete(0);
    end
    if (qScores.size() != 0) begin
      pathValid <= 1'b1;
      pathScores <= qScores[0];
      lastPath <= qLast[0];
    end else begin
      pathValid <= 1'b0;
      pathScores <= ~pathScores;
      lastPath <= ~lastPath;
    end
  end
endmodule

// ---- test/tb_top_score_sorter.sv ----
`timescale 1ns/1ps
`include "tss_consts.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top_score_sorter import tss_pkg::*; ;
  localparam int DEPTH = 8;
  typedef logic [`TSS_PATH_LEN-1:0][`TSS_SCORE_W-1:0] tss_scores_t;
  logic sys_clk, rst_n, queryStart, pathValid, lastPath, pathReady, resultFinal;
  tss_scores_t pathScores;
  tss_entry_t resultList [DEPTH];
  tss_entry_t expList [DEPTH];
  int err_count, n_compared;

  tss_top_sorter #(.RES_DEPTH(DEPTH)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .pathValid(pathValid), .pathScores(pathScores), .lastPath(lastPath),
    .queryStart(queryStart), .pathReady(pathReady), .resultList(resultList),
    .resultFinal(resultFinal));
  tss_seq_model seqModel (.sys_clk(sys_clk), .rst_n(rst_n), .pathReady(pathReady),
    .pathValid(pathValid), .pathScores(pathScores), .lastPath(lastPath));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic tss_entry_t mk(input int s, input int t, input int p);
    tss_entry_t e;
    e.score = 11'(s);
    e.tag = 7'(t);
    e.path = 14'(p);
    return e;
  endfunction

  function automatic tss_scores_t one_hot(input int pos, input int val);
    tss_scores_t s;
    s = '0;
    s[pos] = 11'(val);
    return s;
  endfunction

  // Positions are spread so that every list index and cyclic id region is hit.
  function automatic int pos_of(input int p);
    return (p * 37 + 5) % 128;
  endfunction

  task automatic wrap_up();
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic timed_out();
    err_count++;
    $display("Error handshake wait expected done seen timeout");
    wrap_up();
  endtask

  task automatic check_list();
    for (int i = 0; i < DEPTH; i++) begin
      `CHK("resultList", expList[i], resultList[i])
    end
  endtask

  // Paths are queued back to back, so every offer waits while the sorter is busy.
  task automatic run_paths(input int nPaths, input int midGap, input int lastGap);
    int g;
    g = 0;
    do begin
      @(posedge sys_clk);
      g++;
    end while (!(pathValid === 1'b1 && pathReady === 1'b1) && g < 50);
    if (g >= 50) timed_out();
    for (int k = 0; k < nPaths; k++) begin
      g = 0;
      do begin
        @(posedge sys_clk);
        g++;
        if (g == 1) `CHK("pathReady after take", 1'b0, pathReady)
      end while (pathReady !== 1'b1 && resultFinal !== 1'b1 && g < 400);
      if (g >= 400) timed_out();
      `CHK("cycles to release", (k == nPaths - 1) ? lastGap : midGap, g)
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic check_reset();
    `CHK("pathReady in reset", 1'b1, pathReady)
    `CHK("resultFinal in reset", 1'b0, resultFinal)
    for (int i = 0; i < DEPTH; i++) expList[i] = '0;
    check_list();
  endtask

  // Nine single-winner paths overflow an eight-deep list; the smallest is lost.
  task automatic fill_list();
    for (int p = 0; p < 9; p++) seqModel.offer(one_hot(pos_of(p), 10 * (p + 1)), p == 8);
    run_paths(9, 16, 16 + DEPTH);
    `CHK("resultFinal", 1'b1, resultFinal)
    for (int k = 0; k < DEPTH; k++) expList[k] = mk(10 * (k + 2), pos_of(k + 1), k + 1);
    check_list();
  endtask

  // A new query must restart the path count; an all-zero path inserts nothing.
  task automatic clear_and_reuse();
    queryStart <= 1'b1;
    @(posedge sys_clk);
    queryStart <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK("resultFinal cleared", 1'b0, resultFinal)
    `CHK("pathReady cleared", 1'b1, pathReady)
    for (int i = 0; i < DEPTH; i++) expList[i] = '0;
    check_list();
    seqModel.offer('0, 1'b0);
    seqModel.offer(one_hot(127, 7), 1'b1);
    run_paths(2, 15, 16 + DEPTH);
    expList[DEPTH-1] = mk(7, 127, 1);
    check_list();
  endtask

  // A query start that lands while the list is being flushed must be ignored.
  task automatic ignore_busy_clear();
    int g;
    g = 0;
    queryStart <= 1'b1;
    @(posedge sys_clk);
    queryStart <= 1'b0;
    seqModel.offer(one_hot(3, 5), 1'b1);
    do begin
      @(posedge sys_clk);
      g++;
    end while (!(pathValid === 1'b1 && pathReady === 1'b1) && g < 50);
    if (g >= 50) timed_out();
    repeat (20) @(posedge sys_clk);
    queryStart <= 1'b1;
    @(posedge sys_clk);
    queryStart <= 1'b0;
    g = 0;
    do begin
      @(posedge sys_clk);
      g++;
    end while (resultFinal !== 1'b1 && g < 50);
    if (g >= 50) timed_out();
    `CHK("resultFinal after busy clear", 1'b1, resultFinal)
    expList[DEPTH-1] = mk(5, 3, 0);
    check_list();
  endtask

  initial begin
    err_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    queryStart = 1'b0;
    repeat (3) @(posedge sys_clk);
    check_reset();
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    fill_list();
    clear_and_reuse();
    ignore_busy_clear();
    wrap_up();
  end
endmodule
